// >>> core/fsp_pkg.sv
// constants, command codes and carrier types for the flash status poller
// assumes a 40 MHz controller clock and a 16-bit asynchronous flash bus
package fsp_pkg;
	localparam int ADDR_W = 22;
	localparam int DATA_W = 16;

	// timing, nanoseconds and microseconds as printed, cycles derived
	localparam int CLK_PERIOD_NS = 25;
	localparam int T_ACCESS_NS   = 70;
	localparam int T_WE_NS       = 35;
	localparam int T_RECOV_NS    = 25;
	localparam int T_SE_GAP_US   = 50;
	localparam int ACCESS_CYC    = (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WE_CYC        = (T_WE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RECOV_CYC     = (T_RECOV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SE_GAP_CYC    = (T_SE_GAP_US * 1000) / CLK_PERIOD_NS;
	localparam int SYNC_STAGES   = 2;
	localparam int POLL_MAX_DEF  = 8;
	localparam int CNT_W         = 8;
	localparam int GAP_W         = 12;

	// status bit positions on the data bus
	localparam int BIT_DATA_POLL = 7;
	localparam int BIT_BUSY_TGL  = 6;
	localparam int BIT_TLIM      = 5;
	localparam int BIT_EWIN      = 3;
	localparam int BIT_ESEC_TGL  = 2;

	// command words
	localparam logic [DATA_W-1:0] CMD_RESET        = 16'h00f0;
	localparam logic [DATA_W-1:0] CMD_SECTOR_ERASE = 16'h0030;

	typedef enum logic [2:0] {
		OP_POLL   = 3'h0,
		OP_READ   = 3'h1,
		OP_WRITE  = 3'h2,
		OP_SE_ADD = 3'h3,
		OP_RESET  = 3'h4
	} fsp_op_e;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] dq;
		logic              dq_oe_n;
		logic              ce_n;
		logic              oe_n;
		logic              we_n;
	} fsp_pins_s;

	typedef struct packed {
		logic              ok;
		logic              fail;
		logic              busy;
		logic              suspended;
		logic              sect_erasing;
		logic              win_lost;
		logic [DATA_W-1:0] data;
	} fsp_res_s;

	localparam fsp_pins_s PINS_IDLE = '{addr: '0, dq: '0, dq_oe_n: 1'b1,
		ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
endpackage

// >>> core/fsp_bus_cycle.sv
// single read or write cycle on the asynchronous flash pins
// assumes requests only while idle; data bus is synchronised here
`timescale 1ns/10ps
`default_nettype none
module fsp_bus_cycle (
	// clock and reset
	input  wire logic                        mclk_i,
	input  wire logic                        reset_n_i,
	// cycle request
	input  wire logic                        req_i,
	input  wire logic                        wr_i,
	input  wire logic [fsp_pkg::ADDR_W-1:0]  addr_i,
	input  wire logic [fsp_pkg::DATA_W-1:0]  wdata_i,
	output var  logic                        done_o,
	output var  logic [fsp_pkg::DATA_W-1:0]  rdata_o,
	// flash pins
	output var  fsp_pkg::fsp_pins_s          pins_o,
	input  wire logic [fsp_pkg::DATA_W-1:0]  dq_i
);
	import fsp_pkg::*;

	localparam logic [CNT_W-1:0] RD_LAST = CNT_W'(ACCESS_CYC + SYNC_STAGES - 1);
	localparam logic [CNT_W-1:0] WE_LAST = CNT_W'(WE_CYC - 1);
	localparam logic [CNT_W-1:0] RC_LAST = CNT_W'(RECOV_CYC - 1);

	typedef enum logic [1:0] {
		CY_IDLE   = 2'b00,
		CY_STROBE = 2'b01,
		CY_RECOV  = 2'b11
	} fsp_cy_e;

	fsp_cy_e           st_reg, st_next;
	logic [CNT_W-1:0]  cnt_reg, cnt_next;
	logic              wr_reg, wr_next;
	fsp_pins_s         pins_reg, pins_next;
	logic              done_reg, done_next;
	logic [DATA_W-1:0] rdata_reg, rdata_next;
	logic [DATA_W-1:0] dq_s1_reg, dq_s2_reg;

	always_comb begin
		st_next    = st_reg;
		cnt_next   = cnt_reg;
		wr_next    = wr_reg;
		pins_next  = pins_reg;
		done_next  = 1'b0;
		rdata_next = rdata_reg;
		case (st_reg)
		CY_IDLE: begin
			if (req_i) begin
				st_next           = CY_STROBE;
				wr_next           = wr_i;
				pins_next.addr    = addr_i;
				pins_next.dq      = wdata_i;
				pins_next.dq_oe_n = ~wr_i;
				pins_next.ce_n    = 1'b0;
				pins_next.oe_n    = wr_i;
				pins_next.we_n    = ~wr_i;
				cnt_next          = wr_i ? WE_LAST : RD_LAST;
			end
		end
		CY_STROBE: begin
			if (cnt_reg == '0) begin
				// rising strobe latches a write; data held through recovery
				st_next        = CY_RECOV;
				cnt_next       = RC_LAST;
				pins_next.ce_n = 1'b1;
				pins_next.oe_n = 1'b1;
				pins_next.we_n = 1'b1;
				if (!wr_reg) begin
					rdata_next = dq_s2_reg;
				end
			end else begin
				cnt_next = cnt_reg - 1'b1;
			end
		end
		CY_RECOV: begin
			if (cnt_reg == '0) begin
				st_next           = CY_IDLE;
				done_next         = 1'b1;
				pins_next.dq_oe_n = 1'b1;
			end else begin
				cnt_next = cnt_reg - 1'b1;
			end
		end
		default: begin
			st_next   = CY_IDLE;
			pins_next = PINS_IDLE;
		end
		endcase
	end

	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			st_reg    <= CY_IDLE;
			cnt_reg   <= '0;
			wr_reg    <= 1'b0;
			pins_reg  <= PINS_IDLE;
			done_reg  <= 1'b0;
			rdata_reg <= '0;
			dq_s1_reg <= '0;
			dq_s2_reg <= '0;
		end else begin
			st_reg    <= st_next;
			cnt_reg   <= cnt_next;
			wr_reg    <= wr_next;
			pins_reg  <= pins_next;
			done_reg  <= done_next;
			rdata_reg <= rdata_next;
			dq_s1_reg <= dq_i;
			dq_s2_reg <= dq_s1_reg;
		end
	end

	assign done_o  = done_reg;
	assign rdata_o = rdata_reg;
	assign pins_o  = pins_reg;
endmodule // fsp_bus_cycle
`default_nettype wire

// >>> core/fsp_status_poller.sv
// host-side status poller for a simultaneous read/write flash
// assumes a user that issues one command at a time and waits for res_valid_o
`timescale 1ns/10ps
`default_nettype none
module fsp_status_poller #(
	parameter int POLL_MAX = fsp_pkg::POLL_MAX_DEF
) (
	// clock and reset
	input  wire logic                        mclk_i,
	input  wire logic                        reset_n_i,
	// user command
	input  wire logic                        cmd_valid_i,
	input  wire fsp_pkg::fsp_op_e            cmd_op_i,
	input  wire logic [fsp_pkg::ADDR_W-1:0]  cmd_addr_i,
	input  wire logic [fsp_pkg::DATA_W-1:0]  cmd_data_i,
	output var  logic                        cmd_ready_o,
	// user result
	output var  logic                        res_valid_o,
	output var  fsp_pkg::fsp_res_s           res_o,
	output var  logic                        busy_o,
	// flash pins
	output var  fsp_pkg::fsp_pins_s          pins_o,
	input  wire logic [fsp_pkg::DATA_W-1:0]  dq_i,
	input  wire logic                        ready_busy_n_i
);
	import fsp_pkg::*;

	localparam logic [CNT_W-1:0] POLL_LAST = CNT_W'(POLL_MAX - 1);
	localparam logic [GAP_W-1:0] GAP_MAX   = GAP_W'(SE_GAP_CYC);

	typedef enum logic [3:0] {
		ST_IDLE  = 4'h0,
		ST_RD1   = 4'h1,
		ST_RD2   = 4'h3,
		ST_CHK   = 4'h2,
		ST_RD3   = 4'h6,
		ST_CHK2  = 4'h7,
		ST_RST   = 4'h5,
		ST_DONE  = 4'h4,
		ST_RDD   = 4'hc,
		ST_WPRE  = 4'hd,
		ST_WCMD  = 4'hf,
		ST_WPOST = 4'he,
		ST_RAW   = 4'ha
	} fsp_st_e;

	fsp_st_e           st_reg, st_next;
	fsp_op_e           op_reg, op_next;
	logic [ADDR_W-1:0] addr_reg, addr_next;
	logic [DATA_W-1:0] wdata_reg, wdata_next;
	logic [DATA_W-1:0] prev_reg, prev_next;
	logic [DATA_W-1:0] cur_reg, cur_next;
	logic              wait_reg, wait_next;
	logic [CNT_W-1:0]  poll_cnt_reg, poll_cnt_next;
	logic [GAP_W-1:0]  gap_cnt_reg, gap_cnt_next;
	logic              skip_reg, skip_next;
	fsp_res_s          res_reg, res_next;
	logic              res_valid_reg, res_valid_next;
	logic              ready_reg, ready_next;
	logic              rb_s1_reg, rb_s2_reg, busy_reg;

	logic              cyc_req, cyc_wr, cyc_done, is_acc;
	logic [DATA_W-1:0] cyc_wdata, cyc_rdata;
	logic              bt_tgl, es_tgl, tlim, gap_short;

	assign bt_tgl    = prev_reg[BIT_BUSY_TGL] ^ cur_reg[BIT_BUSY_TGL];
	assign es_tgl    = prev_reg[BIT_ESEC_TGL] ^ cur_reg[BIT_ESEC_TGL];
	assign tlim      = cur_reg[BIT_TLIM];
	assign gap_short = gap_cnt_reg < GAP_MAX;

	// one cycle per access state, issued once per state entry
	always_comb begin
		is_acc = st_reg inside {ST_RD1, ST_RD2, ST_RD3, ST_RDD, ST_RST,
			ST_WPRE, ST_WCMD, ST_WPOST, ST_RAW};
		cyc_req = is_acc && !wait_reg;
		cyc_wr  = (st_reg == ST_RST) || (st_reg == ST_WCMD) ||
			(st_reg == ST_RAW && op_reg == OP_WRITE);
		case (st_reg)
		ST_RST:  cyc_wdata = CMD_RESET;
		ST_WCMD: cyc_wdata = CMD_SECTOR_ERASE;
		default: cyc_wdata = wdata_reg;
		endcase
	end

	fsp_bus_cycle u_cycle (
		.mclk_i    (mclk_i),
		.reset_n_i (reset_n_i),
		.req_i     (cyc_req),
		.wr_i      (cyc_wr),
		.addr_i    (addr_reg),
		.wdata_i   (cyc_wdata),
		.done_o    (cyc_done),
		.rdata_o   (cyc_rdata),
		.pins_o    (pins_o),
		.dq_i      (dq_i)
	);

	always_comb begin
		st_next        = st_reg;
		op_next        = op_reg;
		addr_next      = addr_reg;
		wdata_next     = wdata_reg;
		prev_next      = prev_reg;
		cur_next       = cur_reg;
		wait_next      = wait_reg;
		poll_cnt_next  = poll_cnt_reg;
		gap_cnt_next   = gap_short ? gap_cnt_reg + 1'b1 : gap_cnt_reg;
		skip_next      = skip_reg;
		res_next       = res_reg;
		res_valid_next = 1'b0;
		ready_next     = ready_reg | (st_reg == ST_IDLE);
		if (cyc_req) begin
			wait_next = 1'b1;
		end
		if (cyc_done) begin
			wait_next = 1'b0;
			if (!cyc_wr) begin
				prev_next = cur_reg;
				cur_next  = cyc_rdata;
			end
		end
		case (st_reg)
		ST_IDLE: begin
			if (cmd_valid_i && ready_reg) begin
				ready_next    = 1'b0;
				op_next       = cmd_op_i;
				addr_next     = cmd_addr_i;
				wdata_next    = cmd_data_i;
				res_next      = '0;
				poll_cnt_next = '0;
				skip_next     = gap_short;
				case (cmd_op_i)
				OP_POLL:   st_next = ST_RD1;
				OP_SE_ADD: st_next = gap_short ? ST_WCMD : ST_WPRE;
				OP_RESET:  st_next = ST_RST;
				default:   st_next = ST_RAW;
				endcase
			end
		end
		ST_RD1: if (cyc_done) st_next = ST_RD2;
		ST_RD2: if (cyc_done) st_next = ST_CHK;
		ST_CHK: begin
			res_next.sect_erasing = es_tgl;
			res_next.data         = cur_reg;
			if (!bt_tgl) begin
				res_next.suspended = es_tgl;
				st_next = es_tgl ? ST_DONE : ST_RDD;
			end else if (tlim) begin
				st_next = ST_RD3;
			end else if (poll_cnt_reg == POLL_LAST) begin
				res_next.busy = 1'b1;
				st_next       = ST_DONE;
			end else begin
				poll_cnt_next = poll_cnt_reg + 1'b1;
				st_next       = ST_RD2;
			end
		end
		ST_RD3: if (cyc_done) st_next = ST_CHK2;
		ST_CHK2: begin
			if (!bt_tgl) begin
				st_next = ST_RDD;
			end else begin
				res_next.fail = 1'b1;
				st_next       = ST_RST;
			end
		end
		ST_RDD, ST_RAW: begin
			if (cyc_done) begin
				res_next.ok   = 1'b1;
				res_next.data = cyc_rdata;
				st_next       = ST_DONE;
			end
		end
		ST_RST: begin
			if (cyc_done) begin
				res_next.ok = (op_reg == OP_RESET);
				st_next     = ST_DONE;
			end
		end
		ST_WPRE: begin
			if (cyc_done) begin
				res_next.win_lost = cyc_rdata[BIT_EWIN];
				st_next = cyc_rdata[BIT_EWIN] ? ST_DONE : ST_WCMD;
			end
		end
		ST_WCMD: begin
			if (cyc_done) begin
				gap_cnt_next = '0;
				res_next.ok  = skip_reg;
				st_next      = skip_reg ? ST_DONE : ST_WPOST;
			end
		end
		ST_WPOST: begin
			if (cyc_done) begin
				res_next.win_lost = cyc_rdata[BIT_EWIN];
				res_next.ok       = ~cyc_rdata[BIT_EWIN];
				res_next.data     = cyc_rdata;
				st_next           = ST_DONE;
			end
		end
		ST_DONE: begin
			res_valid_next = 1'b1;
			ready_next     = 1'b1;
			st_next        = ST_IDLE;
		end
		default: st_next = ST_IDLE;
		endcase
	end

	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			st_reg        <= ST_IDLE;
			op_reg        <= OP_POLL;
			addr_reg      <= '0;
			wdata_reg     <= '0;
			prev_reg      <= '0;
			cur_reg       <= '0;
			wait_reg      <= 1'b0;
			poll_cnt_reg  <= '0;
			gap_cnt_reg   <= GAP_MAX;
			skip_reg      <= 1'b0;
			res_reg       <= '0;
			res_valid_reg <= 1'b0;
			ready_reg     <= 1'b0;
			rb_s1_reg     <= 1'b1;
			rb_s2_reg     <= 1'b1;
			busy_reg      <= 1'b0;
		end else begin
			st_reg        <= st_next;
			op_reg        <= op_next;
			addr_reg      <= addr_next;
			wdata_reg     <= wdata_next;
			prev_reg      <= prev_next;
			cur_reg       <= cur_next;
			wait_reg      <= wait_next;
			poll_cnt_reg  <= poll_cnt_next;
			gap_cnt_reg   <= gap_cnt_next;
			skip_reg      <= skip_next;
			res_reg       <= res_next;
			res_valid_reg <= res_valid_next;
			ready_reg     <= ready_next;
			rb_s1_reg     <= ready_busy_n_i;
			rb_s2_reg     <= rb_s1_reg;
			busy_reg      <= ~rb_s2_reg;
		end
	end

	assign cmd_ready_o = ready_reg;
	assign res_valid_o = res_valid_reg;
	assign res_o       = res_reg;
	assign busy_o      = busy_reg;

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!reset_n_i);

	sequence s_fail_reset;
		st_reg == ST_RST && cyc_req && cyc_wr && cyc_wdata == CMD_RESET;
	endsequence
	sequence s_pre_clear;
		st_reg == ST_WPRE && cyc_done && !cyc_rdata[BIT_EWIN];
	endsequence

	AST_DBL_READ: assert property ($rose(st_reg == ST_CHK) |->
		$past(st_reg) == ST_RD2 && $past(cyc_done))
		else $error("check without a second read");
	AST_STOP_DONE: assert property (
		st_reg == ST_CHK && !bt_tgl && !es_tgl |=> st_reg == ST_RDD)
		else $error("steady toggle did not lead to data read");
	AST_TLIM_RECHECK: assert property (
		st_reg == ST_CHK && bt_tgl && tlim |=> st_reg == ST_RD3)
		else $error("limit flag did not trigger a recheck");
	AST_FAIL_RESET: assert property (
		st_reg == ST_CHK2 && bt_tgl |=> s_fail_reset)
		else $error("failure not followed by reset command");
	AST_POLL_START: assert property (st_reg == ST_IDLE &&
		cmd_valid_i && ready_reg && cmd_op_i == OP_POLL
		|=> st_reg == ST_RD1 && poll_cnt_reg == '0)
		else $error("poll did not restart at first read");
	AST_SUSP_MODE: assert property (res_valid_reg &&
		res_reg.suspended |-> !res_reg.ok && res_reg.sect_erasing)
		else $error("suspend report inconsistent");
	AST_SE_GAP: assert property ($rose(st_reg == ST_WCMD) &&
		$past(st_reg) == ST_IDLE |-> $past(gap_short) && skip_reg)
		else $error("window check skipped outside short gap");
	AST_WIN_CHECK: assert property (s_pre_clear |=>
		st_reg == ST_WCMD ##[1:40] st_reg == ST_WPOST)
		else $error("sector erase add lacks second window check");
	AST_VALID_ADDR: assert property ($rose(st_reg == ST_RD1) |->
		cyc_req && !cyc_wr && addr_reg == $past(cmd_addr_i))
		else $error("poll read not at commanded address");
endmodule // fsp_status_poller
`default_nettype wire

// >>> verif/fsp_flash_model.sv
// behavioural flash device answering the status poller's pins
// assumes the bench resolves the shared data bus from the controller's data output enable alone
`timescale 1ns/10ps
`default_nettype none
module fsp_flash_model #(
	parameter int TOUT_NS     = 20000,
	parameter int PROG_READS  = 6,
	parameter int ERASE_READS = 12
) (
	// controller pins
	input  wire fsp_pkg::fsp_pins_s          pins_i,
	// device outputs
	output var  logic [fsp_pkg::DATA_W-1:0]  dq_o,
	output var  logic                        ready_busy_n_o
);
	import fsp_pkg::*;
	logic [DATA_W-1:0] arr [logic [ADDR_W-1:0]];
	logic [9:0]        esect [$];
	logic [9:0]        clean [$];
	logic [ADDR_W-1:0] pa;
	logic [DATA_W-1:0] pd, v;
	logic              busy, erase, susp, tlim, pfail, t6, t2, unlk, sel;
	logic              rcyc, wcyc;
	int                left = 0;
	int                n_reads = 0;
	realtime           t_add = 0;

	initial
		{busy, erase, susp, tlim, pfail, t6, t2, unlk, rcyc, wcyc} = '0;

	function automatic logic [DATA_W-1:0] word(input logic [ADDR_W-1:0] a);
		if (arr.exists(a))
			return arr[a];
		if (a[21:12] inside {clean})
			return '1;
		return a[15:0] ^ 16'h5a50;
	endfunction

	function automatic logic win();
		return erase && ($realtime - t_add >= TOUT_NS);
	endfunction

	assign ready_busy_n_o = !(busy && !susp);

	always @(pins_i.oe_n or pins_i.ce_n) begin
		if (!pins_i.oe_n && !pins_i.ce_n && !rcyc) begin
			rcyc = 1'b1;
			n_reads++;
			sel = erase && (pins_i.addr[21:12] inside {esect});
			v = word(pins_i.addr);
			// status only from the busy bank
			if (busy && pins_i.addr[21:19] == pa[21:19] && (!susp || sel)) begin
				v = '0;
				v[7] = erase ? susp : ~pd[7];
				v[6] = t6;
				v[5] = tlim;
				v[3] = win();
				v[2] = sel & t2;
				if (!susp && (!erase || win()))
					left--;
			end
			if (busy && !susp)
				t6 = ~t6;
			if (busy && sel)
				t2 = ~t2;
			dq_o = v;
			if (busy && !susp && !tlim && left <= 0) begin
				if (pfail)
					tlim = 1'b1;
				else begin
					clean = {clean, esect};
					if (!erase)
						arr[pa] = pd;
					{busy, erase} = '0;
					esect.delete();
				end
			end
		end else if (rcyc && (pins_i.oe_n || pins_i.ce_n)) begin
			// released bus shows the inverse of the last value
			rcyc = 1'b0;
			dq_o = ~dq_o;
		end
	end

	// strobe and select rise together; command acts on the first rise
	always @(pins_i.we_n or pins_i.ce_n) begin
		if (!pins_i.we_n && !pins_i.ce_n)
			wcyc = 1'b1;
		else if (wcyc) begin
			wcyc = 1'b0;
			if (unlk) begin
				unlk = 1'b0;
				pa = pins_i.addr;
				pd = pins_i.dq;
				pfail = |(pd & ~word(pa));
				left = PROG_READS;
				busy = 1'b1;
			end else if (pins_i.dq == CMD_RESET && tlim) begin
				{busy, erase, tlim} = '0;
				esect.delete();
			end else if (pins_i.dq == 16'h00a0 && !busy)
				unlk = 1'b1;
			else if (pins_i.dq == 16'h00b0 && win())
				susp = 1'b1;
			else if (pins_i.dq == CMD_SECTOR_ERASE) begin
				if (susp)
					susp = 1'b0;
				else if (!busy) begin
					{busy, erase, pfail} = 3'h6;
					pa = pins_i.addr;
					left = ERASE_READS;
					esect = {pins_i.addr[21:12]};
					t_add = $realtime;
				end else if (erase && !win()) begin
					esect.push_back(pins_i.addr[21:12]);
					t_add = $realtime;
				end
			end
			// anything else is ignored
		end
	end
endmodule // fsp_flash_model
`default_nettype wire

// >>> verif/tb.sv
// self-checking bench for the flash status poller
// assumes fsp_flash_model on the far side of the flash pins
`timescale 1ns/10ps
`default_nettype none
module tb;
	import fsp_pkg::*;
	localparam logic [ADDR_W-1:0] PA = 22'h080010;
	localparam logic [ADDR_W-1:0] OB = 22'h000004;
	localparam logic [ADDR_W-1:0] EA = 22'h102000;
	localparam logic [DATA_W-1:0] PD = 16'h1a40;
	logic              mclk_i, reset_n_i, cmd_valid_i, cmd_ready_o;
	logic              res_valid_o, busy_o, rb_n;
	fsp_op_e           cmd_op_i;
	logic [ADDR_W-1:0] cmd_addr_i;
	logic [DATA_W-1:0] cmd_data_i, flash_dq, dq_bus, s;
	fsp_res_s          res_o, r;
	fsp_pins_s         pins_o;
	int                n_mismatch = 0;
	int                checked = 0;
	int                base;

	assign dq_bus = pins_o.dq_oe_n ? flash_dq : pins_o.dq;

	fsp_status_poller #(.POLL_MAX(2)) i_dut (.mclk_i(mclk_i),
		.reset_n_i(reset_n_i), .cmd_valid_i(cmd_valid_i),
		.cmd_op_i(cmd_op_i), .cmd_addr_i(cmd_addr_i),
		.cmd_data_i(cmd_data_i), .cmd_ready_o(cmd_ready_o),
		.res_valid_o(res_valid_o), .res_o(res_o), .busy_o(busy_o),
		.pins_o(pins_o), .dq_i(dq_bus), .ready_busy_n_i(rb_n));

	fsp_flash_model i_flash (.pins_i(pins_o), .dq_o(flash_dq),
		.ready_busy_n_o(rb_n));

	initial begin
		mclk_i = 1'b0;
		forever #12.5 mclk_i = ~mclk_i;
	end

	task automatic stop_test;
		$display("checked %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic chk_bit(input logic got, input logic exp, input string m);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t %s", $time, m);
		end
	endtask

	task automatic chk_res(input logic [5:0] f, input logic [DATA_W-1:0] d,
		input logic use_d);
		checked++;
		if (r[21:16] !== f || (use_d && r.data !== d)) begin
			n_mismatch++;
			$display("[FAIL] %0t result %b %h", $time, r[21:16], r.data);
		end
	endtask

	task automatic cmd(input fsp_op_e op, input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] d);
		int n;
		n = 0;
		@(negedge mclk_i);
		while (cmd_ready_o !== 1'b1 && n < 50) begin
			@(negedge mclk_i);
			n++;
		end
		if (cmd_ready_o !== 1'b1) begin
			n_mismatch++;
			$display("[FAIL] %0t not ready", $time);
			stop_test();
		end
		cmd_valid_i = 1'b1;
		cmd_op_i = op;
		cmd_addr_i = a;
		cmd_data_i = d;
		@(negedge mclk_i);
		cmd_valid_i = 1'b0;
		while (res_valid_o !== 1'b1 && n < 600) begin
			@(negedge mclk_i);
			n++;
		end
		if (res_valid_o !== 1'b1) begin
			n_mismatch++;
			$display("[FAIL] %0t no result", $time);
			stop_test();
		end
		r = res_o;
	endtask

	task automatic poll_until(input logic [ADDR_W-1:0] a);
		int n;
		n = 0;
		do begin
			cmd(OP_POLL, a, '0);
			n++;
		end while (r.ok !== 1'b1 && r.fail !== 1'b1 && n < 8);
	endtask

	initial begin
		{reset_n_i, cmd_valid_i} = '0;
		cmd_op_i = OP_READ;
		cmd_addr_i = '0;
		cmd_data_i = '0;
		repeat (12) @(negedge mclk_i);
		chk_bit(&{pins_o.ce_n, pins_o.oe_n, pins_o.we_n, pins_o.dq_oe_n}, 1'b1, "idle pins");
		reset_n_i = 1'b1;
		cmd(OP_READ, OB, '0);
		chk_res(6'b100000, OB[15:0] ^ 16'h5a50, 1'b1);
		base = i_flash.n_reads;
		cmd(OP_POLL, OB, '0);
		chk_res(6'b100000, OB[15:0] ^ 16'h5a50, 1'b1);
		chk_bit(i_flash.n_reads - base == 3, 1'b1, "poll reads");
		$display("test read done");
		cmd(OP_WRITE, PA, 16'h00a0);
		cmd(OP_WRITE, PA, PD);
		repeat (5) @(negedge mclk_i);
		chk_bit(busy_o, 1'b1, "busy flag");
		cmd(OP_READ, PA, '0);
		s = r.data;
		cmd(OP_READ, PA, '0);
		chk_bit(s[6] ^ r.data[6], 1'b1, "busy toggle");
		chk_bit(r.data[7], ~PD[7], "program bit7");
		s = r.data;
		cmd(OP_READ, OB, '0);
		chk_res(6'b100000, OB[15:0] ^ 16'h5a50, 1'b1);
		cmd(OP_READ, PA, '0);
		// other-bank read toggled too, so two toggles cancel
		chk_bit(s[6] ^ r.data[6], 1'b0, "toggle any address");
		poll_until(PA);
		chk_res(6'b100000, PD, 1'b1);
		repeat (5) @(negedge mclk_i);
		chk_bit(busy_o, 1'b0, "ready flag");
		$display("test program done");
		cmd(OP_WRITE, PA, 16'h00a0);
		cmd(OP_WRITE, PA, 16'hffff);
		poll_until(PA);
		chk_res(6'b010000, '0, 1'b0);
		cmd(OP_READ, PA, '0);
		chk_res(6'b100000, PD, 1'b1);
		$display("test failure done");
		cmd(OP_SE_ADD, EA, '0);
		chk_res(6'b100000, '0, 1'b0);
		repeat (200) @(negedge mclk_i);
		cmd(OP_SE_ADD, EA + 22'h001000, '0);
		chk_res(6'b100000, '0, 1'b0);
		repeat (700) @(negedge mclk_i);
		cmd(OP_READ, EA, '0);
		chk_bit(r.data[3], 1'b0, "window restart");
		chk_bit(r.data[7], 1'b0, "erase bit7");
		repeat (2100) @(negedge mclk_i);
		cmd(OP_SE_ADD, EA + 22'h002000, '0);
		chk_res(6'b000001, '0, 1'b0);
		cmd(OP_POLL, EA, '0);
		chk_res(6'b001010, '0, 1'b0);
		cmd(OP_WRITE, EA, 16'h00b0);
		repeat (5) @(negedge mclk_i);
		chk_bit(busy_o, 1'b0, "suspend ready");
		cmd(OP_POLL, EA, '0);
		chk_res(6'b000110, '0, 1'b0);
		cmd(OP_READ, EA + 22'h008000, '0);
		chk_res(6'b100000, 16'ha000 ^ 16'h5a50, 1'b1);
		cmd(OP_WRITE, EA, CMD_SECTOR_ERASE);
		poll_until(EA);
		chk_res(6'b100000, 16'hffff, 1'b1);
		$display("test erase done");
		stop_test();
	end
endmodule // tb
`default_nettype wire
